// ---- hdl/fmbm_host.sv ----
// Host controller driving the four-lane flash module through its pins
// Functional notes
// - Lane selects and write strobes are driven per lane for 8/16/32-bit use.
// - Byte program is a four-write sequence ending with location and value.
// - Sector erase carries the sector address on its final write.
// - Command bytes are replicated on every active byte lane.
// - Several sectors are protected by repeating the protect sequence.
// - Program opens with AA at 5555, 55 at 2AAA, A0 at 5555.
`timescale 1ns/1ns
module fmbm_host (
   input  wire logic               clk_i,
   input  wire logic               reset_i,
   input  wire logic               req_valid_i,
   input  wire fmbm_pkg::fmbm_req_t req_i,
   input  wire logic [31:0]        flash_data_i,
   output fmbm_pkg::fmbm_pins_t    pins_o,
   output logic [31:0]             rdata_o,
   output logic                    busy_o,
   output logic                    done_o
);
   typedef struct packed {
      fmbm_pkg::fmbm_state_t state;
      fmbm_pkg::fmbm_pins_t  pins;
      fmbm_pkg::fmbm_req_t   req;
      logic [2:0]            step;
      logic [3:0]            cnt;
      logic                  polling;
      logic                  first_poll;
      logic [31:0]           last_alt;
      logic                  busy;
      logic                  done;
      logic [31:0]           rdata;
   } fmbm_regs_t;

   fmbm_regs_t r;
   fmbm_regs_t next_r;
   logic [31:0] lane_mask;
   fmbm_pkg::fmbm_beat_t beat;
   localparam int unsigned SECTOR_HI = fmbm_pkg::SECTOR_MSB;
   localparam int unsigned SECTOR_LO = fmbm_pkg::SECTOR_LSB;
   logic        is_read;
   logic [31:0] poll_exp;

   // Byte-lane mask from the enabled lanes
   for (genvar i = 0; i < 4; i++) begin : g_lane
      assign lane_mask[8*i +: 8] = {8{r.req.lanes[i]}};
   end

   // Address and data of the current write step
   always_comb begin
      beat = '{addr: fmbm_pkg::UNLOCK_ADDR1, data: {4{fmbm_pkg::UNLOCK_BYTE1}}, last: 1'b0};
      unique case (r.step)
         3'h0: beat.addr = fmbm_pkg::UNLOCK_ADDR1;
         3'h1: beat = '{addr: fmbm_pkg::UNLOCK_ADDR2, data: {4{fmbm_pkg::UNLOCK_BYTE2}},
                        last: 1'b0};
         3'h2: begin
            beat.data = (r.req.op == fmbm_pkg::OP_PROGRAM) ?
                        {4{fmbm_pkg::CMD_PROGRAM}} : {4{fmbm_pkg::CMD_ERASE}};
         end
         3'h3: begin
            if (r.req.op == fmbm_pkg::OP_PROGRAM) begin
               beat = '{addr: r.req.addr, data: r.req.data, last: 1'b1};
            end
         end
         3'h4: beat = '{addr: fmbm_pkg::UNLOCK_ADDR2, data: {4{fmbm_pkg::UNLOCK_BYTE2}},
                        last: 1'b0};
         default: begin
            beat.last = 1'b1;
            if (r.req.op == fmbm_pkg::OP_SECTOR_ERASE) begin
               beat.addr = r.req.addr;
               beat.data = {4{fmbm_pkg::CMD_SECTOR}};
            end else begin
               beat.data = {4{fmbm_pkg::CMD_CHIP}};
            end
         end
      endcase
      // Protect is a single high-voltage pulse at the sector address
      if (r.req.op == fmbm_pkg::OP_PROTECT) begin
         beat = '{addr: r.req.addr, data: 32'h00000000, last: 1'b1};
      end
   end

   assign is_read  = r.polling || r.req.op == fmbm_pkg::OP_READ ||
                     r.req.op == fmbm_pkg::OP_IDENT;
   // Erased cells poll as ones; programmed cells poll as the written bit 7
   assign poll_exp = (r.req.op == fmbm_pkg::OP_PROGRAM) ? r.req.data :
                     fmbm_pkg::ERASED_WORD;

   always_comb begin
      next_r      = r;
      next_r.done = 1'b0;
      unique case (r.state)
         fmbm_pkg::ST_IDLE: begin
            next_r.pins = fmbm_pkg::PINS_IDLE;
            if (req_valid_i) begin
               next_r.req        = req_i;
               next_r.step       = 3'h0;
               next_r.polling    = 1'b0;
               next_r.first_poll = 1'b0;
               next_r.busy       = 1'b1;
               next_r.state      = fmbm_pkg::ST_SETUP;
            end
         end
         fmbm_pkg::ST_SETUP: begin
            // Address, data and high voltages settle a cycle ahead of strobes
            next_r.pins.addr               = is_read ? r.req.addr : beat.addr;
            next_r.pins.data               = beat.data;
            next_r.pins.data_oe            = !is_read;
            next_r.pins.ident_high_voltage = r.req.op == fmbm_pkg::OP_IDENT ||
                                             r.req.op == fmbm_pkg::OP_PROTECT;
            next_r.pins.gate_high_voltage  = r.req.op == fmbm_pkg::OP_PROTECT;
            next_r.state                   = fmbm_pkg::ST_ASSERT;
         end
         fmbm_pkg::ST_ASSERT: begin
            if (is_read) begin
               next_r.pins.lane_select_n = ~r.req.lanes;
               next_r.pins.out_gate_n    = 1'b0;
               next_r.cnt                = fmbm_pkg::RC_CYC;
            end else if (r.req.cs_style) begin
               next_r.pins.lane_write_strobe_n = ~r.req.lanes;
               next_r.pins.lane_select_n       = ~r.req.lanes;
               next_r.cnt                      = fmbm_pkg::WP_CYC;
            end else begin
               next_r.pins.lane_select_n       = ~r.req.lanes;
               next_r.pins.lane_write_strobe_n = ~r.req.lanes;
               next_r.cnt                      = fmbm_pkg::WP_CYC;
            end
            next_r.state = fmbm_pkg::ST_STROBE;
         end
         fmbm_pkg::ST_STROBE: begin
            next_r.cnt = r.cnt - 4'h1;
            if (r.cnt == 4'h1) begin
               // Select-style writes end on the select edge, strobe drops after
               if (!is_read && r.req.cs_style) begin
                  next_r.pins.lane_select_n = 4'hf;
               end else begin
                  next_r.pins.lane_write_strobe_n = 4'hf;
                  next_r.pins.out_gate_n          = 1'b1;
               end
               if (is_read) begin
                  next_r.rdata = flash_data_i;
               end
               next_r.cnt   = fmbm_pkg::WPH_CYC;
               next_r.state = fmbm_pkg::ST_RECOVER;
            end
         end
         fmbm_pkg::ST_RECOVER: begin
            next_r.pins = fmbm_pkg::PINS_IDLE;
            next_r.pins.addr = r.pins.addr;
            next_r.cnt  = r.cnt - 4'h1;
            if (r.cnt == 4'h1) begin
               next_r.state = fmbm_pkg::ST_SETUP;
               if (r.polling) begin
                  // Done once bit 6 stops alternating and bit 7 reads true
                  next_r.last_alt   = r.rdata & fmbm_pkg::ALT_MASK & lane_mask;
                  next_r.first_poll = 1'b0;
                  if (!r.first_poll &&
                      (r.rdata & fmbm_pkg::ALT_MASK & lane_mask) == r.last_alt &&
                      ((r.rdata ^ poll_exp) & fmbm_pkg::POLL_MASK & lane_mask) == 32'h0) begin
                     next_r.state = fmbm_pkg::ST_IDLE;
                  end
               end else if (is_read) begin
                  next_r.state = fmbm_pkg::ST_IDLE;
               end else if (beat.last && r.req.op != fmbm_pkg::OP_PROTECT) begin
                  next_r.polling    = 1'b1;
                  next_r.first_poll = 1'b1;
               end else if (beat.last) begin
                  next_r.state = fmbm_pkg::ST_IDLE;
               end else begin
                  next_r.step = r.step + 3'h1;
               end
               if (next_r.state == fmbm_pkg::ST_IDLE) begin
                  next_r.busy = 1'b0;
                  next_r.done = 1'b1;
               end
            end
         end
         default: next_r = r;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         r       <= '0;
         r.state <= fmbm_pkg::ST_IDLE;
         r.pins  <= fmbm_pkg::PINS_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign pins_o  = r.pins;
   assign rdata_o = r.rdata;
   assign busy_o  = r.busy;
   assign done_o  = r.done;

   sequence s_cmd_step(logic [2:0] n);
      r.state == fmbm_pkg::ST_ASSERT && !is_read && r.step == n &&
      r.req.op != fmbm_pkg::OP_PROTECT;
   endsequence

   a_read_write_excl: assert property (@(posedge clk_i) disable iff (reset_i)
      !(!r.pins.out_gate_n && r.pins.lane_write_strobe_n != 4'hf))
      else $error("gate and write strobe low together");
   a_drive_gate_high: assert property (@(posedge clk_i) disable iff (reset_i)
      r.pins.data_oe |-> r.pins.out_gate_n)
      else $error("host drives data while gate low");
   a_lane_mask_only: assert property (@(posedge clk_i) disable iff (reset_i)
      (~r.pins.lane_select_n & ~r.req.lanes) == 4'h0)
      else $error("select on a disabled lane");
   a_cmd_replicated: assert property (@(posedge clk_i) disable iff (reset_i)
      (r.pins.data_oe && !(r.req.op == fmbm_pkg::OP_PROGRAM && r.step == fmbm_pkg::PROG_LAST))
      |-> r.pins.data == {4{r.pins.data[7:0]}})
      else $error("command byte not replicated");
   a_unlock_first: assert property (@(posedge clk_i) disable iff (reset_i)
      s_cmd_step(3'h0) |-> r.pins.addr == fmbm_pkg::UNLOCK_ADDR1 &&
      r.pins.data[7:0] == fmbm_pkg::UNLOCK_BYTE1)
      else $error("first unlock write wrong");
   a_unlock_second: assert property (@(posedge clk_i) disable iff (reset_i)
      s_cmd_step(3'h1) |-> r.pins.addr == fmbm_pkg::UNLOCK_ADDR2 &&
      r.pins.data[7:0] == fmbm_pkg::UNLOCK_BYTE2)
      else $error("second unlock write wrong");
   a_strobe_width: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(r.pins.lane_write_strobe_n != 4'hf && !r.req.cs_style) |->
      (r.pins.lane_write_strobe_n != 4'hf)[*5] ##1 (r.pins.lane_write_strobe_n == 4'hf))
      else $error("write pulse width wrong");
   a_sector_addr: assert property (@(posedge clk_i) disable iff (reset_i)
      (s_cmd_step(fmbm_pkg::ERASE_LAST) and r.req.op == fmbm_pkg::OP_SECTOR_ERASE) |->
      r.pins.addr[SECTOR_HI:SECTOR_LO] == r.req.addr[SECTOR_HI:SECTOR_LO])
      else $error("sector address missing on final write");
   a_ident_voltage: assert property (@(posedge clk_i) disable iff (reset_i)
      (r.pins.ident_high_voltage && !r.pins.out_gate_n) |-> r.req.op == fmbm_pkg::OP_IDENT)
      else $error("identifier voltage outside identifier read");
endmodule : fmbm_host

// ---- shared/fmbm_pkg.sv ----
// Constants and types for the flash module bus host controller
package fmbm_pkg;
   localparam int unsigned CLK_NS = 10;
   localparam int unsigned WP_NS  = 50;
   localparam int unsigned WPH_NS = 20;
   localparam int unsigned RC_NS  = 120;
   localparam logic [3:0] WP_CYC  = 4'((WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] WPH_CYC = 4'((WPH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] RC_CYC  = 4'((RC_NS + CLK_NS - 1) / CLK_NS);

   localparam logic [16:0] UNLOCK_ADDR1 = 17'h05555;
   localparam logic [16:0] UNLOCK_ADDR2 = 17'h02aaa;
   localparam logic [7:0]  UNLOCK_BYTE1 = 8'haa;
   localparam logic [7:0]  UNLOCK_BYTE2 = 8'h55;
   localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;
   localparam logic [7:0]  CMD_ERASE    = 8'h80;
   localparam logic [7:0]  CMD_CHIP     = 8'h10;
   localparam logic [7:0]  CMD_SECTOR   = 8'h30;
   localparam logic [31:0] POLL_MASK    = 32'h80808080;
   localparam logic [31:0] ALT_MASK     = 32'h40404040;
   localparam logic [31:0] ERASED_WORD  = 32'hffffffff;
   localparam logic [2:0]  PROG_LAST    = 3'h3;
   localparam logic [2:0]  ERASE_LAST   = 3'h5;
   localparam int unsigned SECTOR_MSB   = 16;
   localparam int unsigned SECTOR_LSB   = 14;

   typedef enum logic [4:0] {
      ST_IDLE    = 5'h01,
      ST_SETUP   = 5'h02,
      ST_ASSERT  = 5'h04,
      ST_STROBE  = 5'h08,
      ST_RECOVER = 5'h10
   } fmbm_state_t;

   typedef enum logic [2:0] {
      OP_READ         = 3'h0,
      OP_PROGRAM      = 3'h1,
      OP_CHIP_ERASE   = 3'h2,
      OP_SECTOR_ERASE = 3'h3,
      OP_IDENT        = 3'h4,
      OP_PROTECT      = 3'h5
   } fmbm_op_t;

   typedef struct packed {
      fmbm_op_t    op;
      logic [16:0] addr;
      logic [31:0] data;
      logic [3:0]  lanes;
      logic        cs_style;
   } fmbm_req_t;

   typedef struct packed {
      logic [16:0] addr;
      logic [31:0] data;
      logic        data_oe;
      logic [3:0]  lane_select_n;
      logic [3:0]  lane_write_strobe_n;
      logic        out_gate_n;
      logic        gate_high_voltage;
      logic        ident_high_voltage;
   } fmbm_pins_t;

   typedef struct packed {
      logic [16:0] addr;
      logic [31:0] data;
      logic        last;
   } fmbm_beat_t;

   localparam fmbm_pins_t PINS_IDLE = '{addr: 17'h00000, data: 32'h00000000,
      data_oe: 1'b0, lane_select_n: 4'hf, lane_write_strobe_n: 4'hf,
      out_gate_n: 1'b1, gate_high_voltage: 1'b0, ident_high_voltage: 1'b0};
endpackage : fmbm_pkg

// ---- sim/fmbm_dev_model.sv ----
// Behavioural model of the four-lane flash module seen by the host
`timescale 1ns/1ns
module fmbm_dev_model #(
   parameter int unsigned PROG_CYC   = 60,
   parameter int unsigned ERASE_CYC  = 200,
   parameter int unsigned ACC_CYC    = 10,
   parameter logic [7:0]  MAKER_CODE = 8'h3c,  // Arbitrary value
   parameter logic [7:0]  DIE_CODE   = 8'h5e   // Arbitrary value
) (
   input  wire fmbm_pkg::fmbm_pins_t pins_i,
   input  wire logic                 clk_i,
   output logic [31:0]               data_o
);
   logic [31:0] mem [logic [16:0]];
   logic [7:0]  prot = 8'h00;
   logic [7:0]  erased = 8'h00;
   logic [31:0] last = 32'h00000000;
   logic [31:0] tgt = 32'h00000000;
   logic [31:0] drv;
   logic [31:0] lane_m;
   logic [16:0] w_addr;
   logic [31:0] w_data;
   logic        w_prot;
   logic        erasing = 1'b0;
   logic        tog = 1'b0;
   logic        was_wr = 1'b0;
   logic        was_rd = 1'b0;
   logic        rd;
   logic        wr;
   int unsigned busy_cnt = 0;
   int unsigned rd_cnt = 0;
   int unsigned n_wr = 0;

   function automatic logic [31:0] word_at(input logic [16:0] a);
      if (mem.exists(a)) begin
         return mem[a];
      end
      return erased[a[16:14]] ? 32'hffffffff : ({a[7:0], 7'h00, a} ^ 32'h5a00c3a5);
   endfunction : word_at

   function automatic logic is_cmd(input logic [16:0] a, input logic [7:0] b);
      return w_addr == a && w_data == {4{b}};
   endfunction : is_cmd

   wire [3:0] s_n = pins_i.lane_select_n;
   assign rd = s_n != 4'hf && !pins_i.out_gate_n && pins_i.lane_write_strobe_n == 4'hf;
   assign wr = s_n != 4'hf && pins_i.out_gate_n && pins_i.lane_write_strobe_n != 4'hf;
   // Data is late on purpose: a host that samples early sees junk
   assign lane_m = {{8{~s_n[3]}}, {8{~s_n[2]}}, {8{~s_n[1]}}, {8{~s_n[0]}}}
                 & {32{rd && rd_cnt >= ACC_CYC}};
   always_comb begin
      if (pins_i.ident_high_voltage) begin
         drv = pins_i.addr[1] ? {4{7'h00, prot[pins_i.addr[16:14]]}}
             : (pins_i.addr[0] ? {4{DIE_CODE}} : {4{MAKER_CODE}});
      end else if (busy_cnt != 0) begin
         drv = (erasing ? 32'h0 : (~tgt & fmbm_pkg::POLL_MASK))
             | (tog ? fmbm_pkg::ALT_MASK : 32'h0);
      end else begin
         drv = word_at(pins_i.addr);
      end
   end
   // Released lanes show the inverse of the last value, never a stale copy
   assign data_o = (drv & lane_m) | (~last & ~lane_m);

   always @(posedge clk_i) begin
      last <= data_o;
      was_rd <= rd;
      was_wr <= wr;
      rd_cnt <= rd ? rd_cnt + 1 : 0;
      if (rd && !was_rd) begin
         tog <= !tog;
      end
      if (busy_cnt != 0) begin
         busy_cnt <= busy_cnt - 1;
      end
      if (wr) begin
         w_addr <= pins_i.addr;
         w_data <= pins_i.data;
         w_prot <= pins_i.gate_high_voltage && pins_i.ident_high_voltage;
      end
      if (was_wr && !wr) begin
         n_wr <= 0;
         if (w_prot) begin
            prot[w_addr[16:14]] <= 1'b1;
         end else if (n_wr == 3) begin
            mem[w_addr] = word_at(w_addr) & w_data;
            tgt <= w_data;
            erasing <= 1'b0;
            busy_cnt <= PROG_CYC;
         end else if (n_wr == 6 && w_data == {4{fmbm_pkg::CMD_CHIP}}) begin
            mem.delete();
            erased <= 8'hff;
            erasing <= 1'b1;
            busy_cnt <= ERASE_CYC;
         end else if (n_wr == 6 && w_data == {4{fmbm_pkg::CMD_SECTOR}}) begin
            foreach (mem[k]) if (k[16:14] == w_addr[16:14]) mem[k] = 32'hffffffff;
            erased[w_addr[16:14]] <= 1'b1;
            erasing <= 1'b1;
            busy_cnt <= ERASE_CYC;
         end else if (is_cmd(fmbm_pkg::UNLOCK_ADDR1, fmbm_pkg::UNLOCK_BYTE1)) begin
            n_wr <= (n_wr == 4) ? 5 : 1;
         end else if (is_cmd(fmbm_pkg::UNLOCK_ADDR2, fmbm_pkg::UNLOCK_BYTE2)) begin
            n_wr <= (n_wr == 1 || n_wr == 5) ? n_wr + 1 : 0;
         end else if (n_wr == 2 && is_cmd(fmbm_pkg::UNLOCK_ADDR1, fmbm_pkg::CMD_PROGRAM)) begin
            n_wr <= 3;
         end else if (n_wr == 2 && is_cmd(fmbm_pkg::UNLOCK_ADDR1, fmbm_pkg::CMD_ERASE)) begin
            n_wr <= 4;
         end
      end
   end
endmodule : fmbm_dev_model

// ---- sim/tb_flash_module_bus_modes.sv ----
// Self-checking bench for the flash module host controller
`timescale 1ns/1ns
module tb_flash_module_bus_modes;
   localparam logic [7:0] MAKER = 8'h3c;  // Arbitrary value
   localparam logic [7:0] DIE   = 8'h5e;  // Arbitrary value
   typedef struct packed {
      logic [2:0]  op;
      logic [16:0] addr;
      logic [3:0]  lanes;
      logic [31:0] exp;
      logic [31:0] mask;
   } fmbm_row_t;
   logic                 clk_i = 1'b0;
   logic                 reset_i = 1'b1;
   logic                 req_valid_i = 1'b0;
   fmbm_pkg::fmbm_req_t  req_i = '0;
   logic [31:0]          fdata;
   fmbm_pkg::fmbm_pins_t pins;
   logic [31:0]          rdata;
   logic                 busy;
   logic                 done;
   int                   n_errors = 0;
   int                   num_checks = 0;
   int                   cycles = 0;
   fmbm_row_t            rows [6];

   fmbm_host DUT (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .flash_data_i(fdata), .pins_o(pins), .rdata_o(rdata), .busy_o(busy), .done_o(done));
   fmbm_dev_model #(.PROG_CYC(60), .ERASE_CYC(200), .MAKER_CODE(MAKER), .DIE_CODE(DIE))
      flash (.pins_i(pins), .clk_i(clk_i), .data_o(fdata));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   function automatic logic [31:0] word(input logic [16:0] a);
      return {a[7:0], 7'h00, a} ^ 32'h5a00c3a5;
   endfunction : word

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("Checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   task automatic start(input logic [2:0] op, input logic [16:0] a, input logic [31:0] d,
                        input logic [3:0] ln, input logic cs);
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_i <= '{op: fmbm_pkg::fmbm_op_t'(op), addr: a, data: d, lanes: ln, cs_style: cs};
      @(posedge clk_i);
      req_valid_i <= 1'b0;
   endtask : start

   task automatic wait_done();
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (done !== 1'b1 && n < 3000);
      check({31'h0, done}, 32'h1);
   endtask : wait_done

   task automatic run_op(input logic [2:0] op, input logic [16:0] a, input logic [31:0] d,
                         input logic cs);
      start(op, a, d, 4'hf, cs);
      wait_done();
   endtask : run_op

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         n_errors++;
         close_out();
      end
   end

   initial begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      #1;
      check({20'h0, pins.lane_select_n, pins.lane_write_strobe_n, pins.out_gate_n,
             pins.data_oe, busy, done}, 32'h00000ff8);
      check(rdata, 32'h0);
      $display("Test reset done");
      rows = '{'{3'h0, 17'h00123, 4'hf, word(17'h00123), 32'hffffffff},
               '{3'h0, 17'h1ffff, 4'h3, word(17'h1ffff), 32'h0000ffff},
               '{3'h0, 17'h0a5a5, 4'h8, word(17'h0a5a5), 32'hff000000},
               '{3'h4, 17'h00000, 4'hf, {4{MAKER}}, 32'hffffffff},
               '{3'h4, 17'h00001, 4'hf, {4{DIE}}, 32'hffffffff},
               '{3'h4, 17'h00002, 4'hf, 32'h0, 32'hffffffff}};
      foreach (rows[i]) begin
         start(rows[i].op, rows[i].addr, 32'h0, rows[i].lanes, 1'b0);
         wait_done();
         check(rdata & rows[i].mask, rows[i].exp & rows[i].mask);
         $display("Test row %0d done", i);
      end
      run_op(3'h3, 17'h0c000, 32'h0, 1'b0);
      check(rdata, 32'hffffffff);
      run_op(3'h0, 17'h0c010, 32'h0, 1'b0);
      check(rdata, 32'hffffffff);
      run_op(3'h0, 17'h00123, 32'h0, 1'b0);
      check(rdata, word(17'h00123));
      for (int s = 0; s < 2; s++) begin
         run_op(3'h1, 17'h0c010 + 17'(s), 32'h12345678 ^ {32{s[0]}}, s[0]);
         check(rdata, 32'h12345678 ^ {32{s[0]}});
         run_op(3'h0, 17'h0c010 + 17'(s), 32'h0, 1'b0);
         check(rdata, 32'h12345678 ^ {32{s[0]}});
         $display("Test program style %0d done", s);
      end
      run_op(3'h2, 17'h1ffff, 32'h0, 1'b0);
      check(rdata, 32'hffffffff);
      run_op(3'h0, 17'h0c010, 32'h0, 1'b0);
      check(rdata, 32'hffffffff);
      for (int s = 2; s < 4; s++) begin
         run_op(3'h5, 17'(s) << 14, 32'h0, 1'b0);
         run_op(3'h4, (17'(s) << 14) | 17'h00002, 32'h0, 1'b0);
         check(rdata, 32'h01010101);
      end
      $display("Test erase and protect done");
      // Second request during busy must be dropped, else busy is still high at the check below
      start(3'h0, 17'h00040, 32'h0, 4'hf, 1'b0);
      run_op(3'h1, 17'h00040, 32'h0, 1'b0);
      check(rdata, 32'hffffffff);
      repeat (3) @(posedge clk_i);
      #1 check({31'h0, busy}, 32'h0);
      start(3'h1, 17'h00080, 32'h0, 4'hf, 1'b0);
      repeat (25) @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      #1 check({20'h0, pins.lane_select_n, pins.lane_write_strobe_n, pins.out_gate_n,
                pins.data_oe, busy, done}, 32'h00000ff8);
      run_op(3'h0, 17'h00080, 32'h0, 1'b0);
      check(rdata, 32'hffffffff);
      $display("Test refusal and reset done");
      close_out();
   end
endmodule : tb_flash_module_bus_modes
